// [logic/ofac_params.svh]
/*
  Constants of the output format and analog control block: register
  subaddresses, field positions, reset values, format codes and timing
  code bytes. Assumes it is included by its bare name.
*/
`ifndef OFAC_PARAMS_SVH
`define OFAC_PARAMS_SVH

// ----------------------------------------------------------------
// register subaddresses
// ----------------------------------------------------------------
`define OFAC_ADDR_FORMAT     8'h13
`define OFAC_ADDR_CONTROL    8'h14
`define OFAC_ADDR_START_LOW  8'h15
`define OFAC_ADDR_STOP_LOW   8'h16
`define OFAC_ADDR_GATE_MSB   8'h17
`define OFAC_ADDR_STATUS     8'h1f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OFAC_RST_FORMAT      3'h0
`define OFAC_RST_CONTROL     8'h00
`define OFAC_RST_LINE        9'h000
`define OFAC_RST_SHIFT       1'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OFAC_FMT_HI          2
`define OFAC_CTL_COMPAT      7
`define OFAC_CTL_GAIN        6
`define OFAC_CTL_TEST_HI     5
`define OFAC_CTL_TEST_LO     4
`define OFAC_CTL_LEGACY      2
`define OFAC_CTL_PHASE_HI    1
`define OFAC_CTL_PHASE_LO    0
`define OFAC_MSB_START       0
`define OFAC_MSB_STOP        1
`define OFAC_MSB_SHIFT       2

// ----------------------------------------------------------------
// output format codes
// ----------------------------------------------------------------
`define OFAC_FMT_656         3'h0
`define OFAC_FMT_GATED       3'h1
`define OFAC_FMT_RAW         3'h2
`define OFAC_FMT_BYP_HIGH    3'h4
`define OFAC_FMT_BYP_LOW     3'h5
`define OFAC_FMT_BYP_SPLIT   3'h7

// ----------------------------------------------------------------
// timing code bytes and output buffer depth
// ----------------------------------------------------------------
`define OFAC_CODE_PRE_FF     8'hff
`define OFAC_CODE_PRE_00     8'h00
`define OFAC_BUF_DEPTH       2

`endif

// [logic/ofac_pkg.sv]
/*
  Types of the output format and analog control block.
  Assumes nothing of its surroundings.
*/
package ofac_pkg;

  // decoded component stream from the decoder core
  typedef struct packed {
    logic [7:0] data;
    logic       code_slot;
    logic [1:0] code_idx;
    logic       eav;
    logic       v_blank;
    logic       field;
    logic       line_start;
    logic       field_start;
  } ofac_stream_t;

  // raw converter samples
  typedef struct packed {
    logic [1:0] enable;
    logic [8:0] one;
    logic [8:0] two;
  } ofac_conv_t;

  // one byte of the expansion port
  typedef struct packed {
    logic [7:0] data;
    logic       qualifier;
  } ofac_port_t;

  // subaddress access from the serial control bus back end
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ofac_reg_req_t;

endpackage

// [logic/ofac_pair_buffer.sv]
/*
  Two-entry skid buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "ofac_params.svh"

module ofac_pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `OFAC_BUF_DEPTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("pair buffer serves exactly two entries and a positive width");
    end
  end

  logic             out_valid;
  logic [WIDTH-1:0] out_data;
  logic             skid_valid;
  logic [WIDTH-1:0] skid_data;
  logic             in_ready;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             next_skid_valid;
  logic [WIDTH-1:0] next_skid_data;
  logic             next_in_ready;
  logic             pop;
  logic             push;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pop             = out_valid & i_out_ready;
    push            = i_in_valid & in_ready;
    next_out_valid  = out_valid;
    next_out_data   = out_data;
    next_skid_valid = skid_valid;
    next_skid_data  = skid_data;
    if (skid_valid) begin
      if (pop) begin
        next_out_data   = skid_data;
        next_skid_valid = 1'b0;
      end
    end else if (push) begin
      if (!out_valid || pop) begin
        next_out_data  = i_in_data;
        next_out_valid = 1'b1;
      end else begin
        next_skid_data  = i_in_data;
        next_skid_valid = 1'b1;
      end
    end else if (pop) begin
      next_out_valid = 1'b0;
    end
    next_in_ready = ~next_skid_valid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      out_valid  <= 1'b0;
      out_data   <= '0;
      skid_valid <= 1'b0;
      skid_data  <= '0;
      in_ready   <= 1'b1;
    end else begin
      out_valid  <= next_out_valid;
      out_data   <= next_out_data;
      skid_valid <= next_skid_valid;
      skid_data  <= next_skid_data;
      in_ready   <= next_in_ready;
    end
  end

  assign o_in_ready  = in_ready;
  assign o_out_valid = out_valid;
  assign o_out_data  = out_data;

endmodule

// [logic/ofac_output_format.sv]
/*
  Expansion port output format selector with analog, converter and
  compatibility control, vertical gate window and field identifier.
  Assumes a subaddress access port behind the serial control bus, a
  decoded stream and converter samples on the same line-locked clock.
*/
`timescale 1ns/100ps
`include "ofac_params.svh"

// How it works
// - format 000 sends the byte stream with embedded timing codes.
// - format 001 sends timing codes whose blanking follows the gate window.
// - format 010 sends 4:2:2 bytes and drops the timing code slots.
// - format 100 bypasses converter bits 8..1, two at qualifier high when both are enabled, else the enabled one.
// - format 101 bypasses converter bits 7..0, two at qualifier high when both are enabled, else the enabled one.
// - format 111 sends one converter, upper bits high, lower bits low.
// - control bit 7 enables the re-encoder compatibility mode, off by default.
// - control bit 6 picks gain update once per line or once per field.
// - control bits 5..4 route the analog test pin.
// - control bit 2 picks the standard or legacy status byte layout.
// - control bits 1..0 set the converter sample clock phase.
// - gate rises and field identifier follows field at start line.
// - gate falls at the nine-bit stop line.
// - field-2 shift moves the gate one line earlier in field two.
module ofac_output_format (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  input  wire ofac_pkg::ofac_reg_req_t i_reg,
  output logic [7:0]                  o_reg_rdata,
  input  wire logic [7:0]             i_decoder_status,
  input  wire logic                   i_stream_valid,
  input  wire ofac_pkg::ofac_stream_t i_stream,
  output logic                        o_stream_ready,
  input  wire ofac_pkg::ofac_conv_t   i_conv,
  input  wire logic                   i_clock_reference_qualifier,
  output logic                        o_port_valid,
  output ofac_pkg::ofac_port_t        o_expansion_port_data,
  input  wire logic                   i_port_ready,
  output logic                        o_vertical_gate_window,
  output logic                        o_field_identifier,
  output logic                        o_gain_update_strobe,
  output logic                        o_gain_update_interval,
  output logic [1:0]                  o_analog_test_select,
  output logic                        o_legacy_status_layout,
  output logic [1:0]                  o_sample_clock_phase,
  output logic                        o_reencoder_compat_mode
);
  import ofac_pkg::*;

  localparam int PORT_W = $bits(ofac_port_t);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [2:0] output_format_select;
  logic [7:0] control;
  logic [8:0] gate_start_line;
  logic [8:0] gate_stop_line;
  logic       gate_field2_shift;
  logic [7:0] reg_rdata;
  logic [2:0] next_format;
  logic [7:0] next_control;
  logic [8:0] next_start;
  logic [8:0] next_stop;
  logic       next_shift;
  logic [7:0] next_rdata;
  logic [7:0] status_view;

  always_comb begin
    next_format = output_format_select;
    next_control = control;
    next_start  = gate_start_line;
    next_stop   = gate_stop_line;
    next_shift  = gate_field2_shift;
    next_rdata  = reg_rdata;
    if (control[`OFAC_CTL_LEGACY]) begin
      status_view = {i_decoder_status[3:0], i_decoder_status[7:4]};
    end else begin
      status_view = i_decoder_status;
    end
    if (i_reg.write) begin
      case (i_reg.addr)
        `OFAC_ADDR_FORMAT: begin
          next_format = i_reg.wdata[`OFAC_FMT_HI:0];
        end
        `OFAC_ADDR_CONTROL: begin
          next_control = i_reg.wdata;
        end
        `OFAC_ADDR_START_LOW: begin
          next_start[7:0] = i_reg.wdata;
        end
        `OFAC_ADDR_STOP_LOW: begin
          next_stop[7:0] = i_reg.wdata;
        end
        `OFAC_ADDR_GATE_MSB: begin
          next_start[8] = i_reg.wdata[`OFAC_MSB_START];
          next_stop[8]  = i_reg.wdata[`OFAC_MSB_STOP];
          next_shift    = i_reg.wdata[`OFAC_MSB_SHIFT];
        end
        default: begin
          next_shift = gate_field2_shift;
        end
      endcase
    end
    if (i_reg.read) begin
      case (i_reg.addr)
        `OFAC_ADDR_FORMAT:    next_rdata = {5'h00, output_format_select};
        `OFAC_ADDR_CONTROL:   next_rdata = control;
        `OFAC_ADDR_START_LOW: next_rdata = gate_start_line[7:0];
        `OFAC_ADDR_STOP_LOW:  next_rdata = gate_stop_line[7:0];
        `OFAC_ADDR_GATE_MSB: begin
          next_rdata = {5'h00, gate_field2_shift, gate_stop_line[8], gate_start_line[8]};
        end
        `OFAC_ADDR_STATUS:    next_rdata = status_view;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      output_format_select <= `OFAC_RST_FORMAT;
      control              <= `OFAC_RST_CONTROL;
      gate_start_line      <= `OFAC_RST_LINE;
      gate_stop_line       <= `OFAC_RST_LINE;
      gate_field2_shift    <= `OFAC_RST_SHIFT;
      reg_rdata            <= 8'h00;
    end else begin
      output_format_select <= next_format;
      control              <= next_control;
      gate_start_line      <= next_start;
      gate_stop_line       <= next_stop;
      gate_field2_shift    <= next_shift;
      reg_rdata            <= next_rdata;
    end
  end

  assign o_reg_rdata             = reg_rdata;
  assign o_reencoder_compat_mode = control[`OFAC_CTL_COMPAT];
  assign o_gain_update_interval  = control[`OFAC_CTL_GAIN];
  assign o_analog_test_select    = control[`OFAC_CTL_TEST_HI:`OFAC_CTL_TEST_LO];
  assign o_legacy_status_layout  = control[`OFAC_CTL_LEGACY];
  assign o_sample_clock_phase    = control[`OFAC_CTL_PHASE_HI:`OFAC_CTL_PHASE_LO];

  // ----------------------------------------------------------------
  // line count, gate window, field identifier, gain update
  // ----------------------------------------------------------------
  logic       stream_ready;
  logic       accept;
  logic [8:0] line_count;
  logic       vertical_gate_window;
  logic       field_identifier;
  logic       gain_strobe;
  logic [8:0] next_line;
  logic [8:0] eff_line;
  logic       next_gate;
  logic       next_fid;
  logic       next_strobe;

  assign accept = i_stream_valid & stream_ready;

  always_comb begin
    next_line   = line_count;
    next_gate   = vertical_gate_window;
    next_fid    = field_identifier;
    next_strobe = 1'b0;
    if (accept && i_stream.line_start) begin
      if (i_stream.field_start) begin
        next_line = 9'h000;
      end else begin
        next_line = 9'(line_count + 9'h001);
      end
    end
    if (gate_field2_shift && i_stream.field) begin
      eff_line = 9'(next_line + 9'h001);
    end else begin
      eff_line = next_line;
    end
    if (accept && i_stream.line_start) begin
      if (eff_line == gate_stop_line) begin
        next_gate = 1'b0;
      end
      if (eff_line == gate_start_line) begin
        next_gate = 1'b1;
        next_fid  = i_stream.field;
      end
      if (control[`OFAC_CTL_GAIN]) begin
        next_strobe = i_stream.field_start;
      end else begin
        next_strobe = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      line_count           <= 9'h000;
      vertical_gate_window <= 1'b0;
      field_identifier     <= 1'b0;
      gain_strobe          <= 1'b0;
    end else begin
      line_count           <= next_line;
      vertical_gate_window <= next_gate;
      field_identifier     <= next_fid;
      gain_strobe          <= next_strobe;
    end
  end

  assign o_vertical_gate_window = vertical_gate_window;
  assign o_field_identifier     = field_identifier;
  assign o_gain_update_strobe   = gain_strobe;

  // ----------------------------------------------------------------
  // output format selection
  // ----------------------------------------------------------------
  logic       keep;
  logic [7:0] port_byte;
  logic [7:0] code_xy;
  logic       code_v;
  logic       code_f;
  logic       code_h;
  logic [8:0] both_pick;
  logic [8:0] single_pick;

  always_comb begin
    code_f = i_stream.field;
    code_h = i_stream.eav;
    if (output_format_select == `OFAC_FMT_GATED) begin
      code_v = vertical_gate_window;
    end else begin
      code_v = i_stream.v_blank;
    end
    code_xy = {1'b1, code_f, code_v, code_h, code_v ^ code_h, code_f ^ code_h,
               code_f ^ code_v, code_f ^ code_v ^ code_h};
    if (&i_conv.enable) begin
      both_pick = i_clock_reference_qualifier ? i_conv.two : i_conv.one;
    end else begin
      both_pick = i_conv.enable[1] ? i_conv.two : i_conv.one;
    end
    single_pick = i_conv.enable[0] ? i_conv.one : i_conv.two;
    keep        = 1'b1;
    port_byte   = i_stream.data;
    case (output_format_select)
      `OFAC_FMT_656, `OFAC_FMT_GATED: begin
        if (i_stream.code_slot) begin
          case (i_stream.code_idx)
            2'h0:    port_byte = `OFAC_CODE_PRE_FF;
            2'h1:    port_byte = `OFAC_CODE_PRE_00;
            2'h2:    port_byte = `OFAC_CODE_PRE_00;
            default: port_byte = code_xy;
          endcase
        end
      end
      `OFAC_FMT_RAW: begin
        keep = ~i_stream.code_slot;
      end
      `OFAC_FMT_BYP_HIGH: begin
        port_byte = both_pick[8:1];
      end
      `OFAC_FMT_BYP_LOW: begin
        port_byte = both_pick[7:0];
      end
      `OFAC_FMT_BYP_SPLIT: begin
        if (i_clock_reference_qualifier) begin
          port_byte = single_pick[8:1];
        end else begin
          port_byte = single_pick[7:0];
        end
      end
      default: begin
        keep      = 1'b0;
        port_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  ofac_port_t push_word;
  logic       push_valid;

  assign push_word  = '{data: port_byte, qualifier: i_clock_reference_qualifier};
  assign push_valid = i_stream_valid & keep;

  ofac_pair_buffer #(
    .WIDTH (PORT_W),
    .DEPTH (`OFAC_BUF_DEPTH)
  ) u_buffer (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .i_in_data   (push_word),
    .o_in_ready  (stream_ready),
    .o_out_valid (o_port_valid),
    .o_out_data  (o_expansion_port_data),
    .i_out_ready (i_port_ready)
  );

  assign o_stream_ready = stream_ready;

endmodule

// [sim/ofac_output_format_properties.sv]
/*
  Port checker of the output format block.
  Assumes a bind onto ofac_output_format by name.
*/
`timescale 1ns/100ps
`include "ofac_params.svh"
module ofac_output_format_properties (
  input wire logic                    i_clock,
  input wire logic                    i_reset,
  input wire ofac_pkg::ofac_reg_req_t i_reg,
  input wire logic [7:0]              o_reg_rdata,
  input wire logic [7:0]              i_decoder_status,
  input wire logic                    i_stream_valid,
  input wire ofac_pkg::ofac_stream_t  i_stream,
  input wire logic                    o_stream_ready,
  input wire logic                    o_port_valid,
  input wire ofac_pkg::ofac_port_t    o_expansion_port_data,
  input wire logic                    i_port_ready,
  input wire logic                    o_vertical_gate_window,
  input wire logic                    o_field_identifier,
  input wire logic                    o_gain_update_strobe,
  input wire logic                    o_gain_update_interval,
  input wire logic [1:0]              o_analog_test_select,
  input wire logic                    o_legacy_status_layout,
  input wire logic [1:0]              o_sample_clock_phase,
  input wire logic                    o_reencoder_compat_mode
);
  // --------
  // shadow of gate registers and line count
  // --------
  logic [8:0] start, stop, line, nl, eff;
  logic [7:0] wd_q, swap;
  logic       shift, ls, cause, fld, wctl;
  assign wctl  = i_reg.write && i_reg.addr == `OFAC_ADDR_CONTROL;
  assign ls    = i_stream_valid && o_stream_ready && i_stream.line_start;
  assign fld   = i_stream.field;
  assign nl    = i_stream.field_start ? 9'h000 : line + 9'h001;
  assign eff   = nl + {8'h00, shift && fld};
  assign swap  = {i_decoder_status[3:0], i_decoder_status[7:4]};
  assign cause = ls && (i_stream.field_start || !o_gain_update_interval);
  always_ff @(posedge i_clock) begin
    wd_q <= i_reg.wdata;
    if (i_reset) begin
      start <= 9'h000;
      stop  <= 9'h000;
      line  <= 9'h000;
      shift <= 1'h0;
    end else begin
      if (i_reg.write) begin
        case (i_reg.addr)
          `OFAC_ADDR_START_LOW: start[7:0] <= i_reg.wdata;
          `OFAC_ADDR_STOP_LOW:  stop[7:0] <= i_reg.wdata;
          `OFAC_ADDR_GATE_MSB:  {shift, stop[8], start[8]} <= i_reg.wdata[2:0];
          default: ;
        endcase
      end
      if (ls) line <= nl;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // --------
  // properties
  // --------
  property p_compat;
    wctl |=> o_reencoder_compat_mode == wd_q[7];
  endproperty
  a_compat: assert property (p_compat)
    else $error("compat");
  property p_test;
    wctl |=> o_analog_test_select == wd_q[5:4];
  endproperty
  a_test: assert property (p_test)
    else $error("test select");
  property p_phase;
    wctl |=> o_sample_clock_phase == wd_q[1:0];
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase");
  property p_status;
    i_reg.read && i_reg.addr == `OFAC_ADDR_STATUS |=>
      o_reg_rdata == $past(o_legacy_status_layout ? swap : i_decoder_status);
  endproperty
  a_status: assert property (p_status)
    else $error("status");
  property p_strobe;
    !$past(i_reset) |-> o_gain_update_strobe == $past(cause);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe");
  property p_rise;
    ls && eff == start |=> o_vertical_gate_window && o_field_identifier == $past(fld);
  endproperty
  a_rise: assert property (p_rise)
    else $error("gate rise");
  property p_fall;
    ls && eff == stop && eff != start |=> !o_vertical_gate_window;
  endproperty
  a_fall: assert property (p_fall)
    else $error("gate fall");
  property p_shift;
    ls && shift && fld && nl + 9'h001 == start |=> o_vertical_gate_window;
  endproperty
  a_shift: assert property (p_shift)
    else $error("early gate");
  property p_hold;
    o_port_valid && !i_port_ready |=> o_port_valid && $stable(o_expansion_port_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stall hold");
endmodule

// [sim/ofac_port_sink.sv]
/*
  Downstream model of the expansion port: takes bytes, may stall.
  Assumes the clock and reset of the block.
*/
`timescale 1ns/100ps
module ofac_port_sink (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset,
  input  wire logic                 i_valid,
  input  wire ofac_pkg::ofac_port_t i_data,
  input  wire logic                 i_hold,
  input  wire logic                 i_slow,
  output logic                      o_ready
);
  import ofac_pkg::*;
  ofac_port_t got_q[$];
  initial o_ready = 1'b0;
  // slow mode takes every other cycle, hold stalls fully
  always @(posedge i_clock) begin
    if (!i_reset && i_valid && o_ready) got_q.push_back(i_data);
    o_ready <= !i_reset && !i_hold && (!i_slow || !o_ready);
  end
endmodule

// [sim/output_format_adc_control_tb.sv]
/*
  Self-checking bench of the output format block.
  Assumes the design files, the port sink and the checker.
*/
`timescale 1ns/100ps
`include "ofac_params.svh"
module output_format_adc_control_tb;
  import ofac_pkg::*;
  logic          i_clock, i_reset, i_stream_valid, i_clock_reference_qualifier, i_port_ready;
  logic          o_stream_ready, o_port_valid, o_vertical_gate_window, o_field_identifier;
  logic          o_gain_update_strobe, o_gain_update_interval, o_legacy_status_layout;
  logic          o_reencoder_compat_mode, sink_hold, sink_slow;
  logic [1:0]    o_analog_test_select, o_sample_clock_phase;
  logic [7:0]    o_reg_rdata, i_decoder_status, d, r;
  ofac_reg_req_t i_reg;
  ofac_stream_t  i_stream;
  ofac_conv_t    i_conv;
  ofac_port_t    o_expansion_port_data;
  int            mismatches, tests_run;
  localparam logic [13:0] BYP [9] = '{{3'h4, 2'h3, 1'h1, 8'h61}, {3'h4, 2'h3, 1'h0, 8'hd2},
    {3'h5, 2'h3, 1'h1, 8'hc3}, {3'h5, 2'h3, 1'h0, 8'ha5}, {3'h4, 2'h1, 1'h1, 8'hd2},
    {3'h7, 2'h1, 1'h1, 8'hd2}, {3'h7, 2'h1, 1'h0, 8'ha5}, {3'h7, 2'h2, 1'h1, 8'h61},
    {3'h7, 2'h2, 1'h0, 8'hc3}};

  ofac_output_format u_ofac_output_format (.*);
  ofac_port_sink u_ofac_port_sink (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_valid (o_port_valid),
    .i_data  (o_expansion_port_data),
    .i_hold  (sink_hold),
    .i_slow  (sink_slow),
    .o_ready (i_port_ready)
  );

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // --------
  // shared tasks
  // --------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_port(input ofac_port_t exp);
    int n = 0;
    while (u_ofac_port_sink.got_q.size() == 0 && n < 50) begin
      @(posedge i_clock);
      n++;
    end
    tests_run++;
    if (n == 50 || u_ofac_port_sink.got_q.pop_front() !== exp) begin
      mismatches++;
      $display("MISMATCH %0t port byte expected %h", $time, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_reg <= '{1'b1, 1'b0, a, v};
    @(posedge i_clock);
    i_reg <= '0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_reg <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clock);
    i_reg <= '0;
    @(posedge i_clock);
    v = o_reg_rdata;
  endtask
  function automatic ofac_stream_t sb(logic [7:0] v, logic cs, logic [1:0] ix, logic h,
                                      logic vb, logic f, logic ls, logic fs);
    return '{v, cs, ix, h, vb, f, ls, fs};
  endfunction
  function automatic logic [7:0] xy(logic f, logic v, logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction
  task automatic send(input ofac_stream_t s, input logic q);
    i_stream <= s;
    i_clock_reference_qualifier <= q;
    i_stream_valid <= 1'b1;
    do @(posedge i_clock); while (o_stream_ready !== 1'b1);
  endtask
  task automatic idle;
    i_stream_valid <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic send_code(input logic f, input logic vb, input logic h, input logic ve);
    for (int i = 0; i < 4; i++) send(sb(8'h11, 1'b1, 2'(i), h, vb, f, 1'b0, 1'b0), 1'b0);
    send(sb(8'h80, 1'b0, 2'h0, h, vb, f, 1'b0, 1'b0), 1'b0);
    idle;
    chk_port('{8'hff, 1'b0});
    chk_port('{8'h00, 1'b0});
    chk_port('{8'h00, 1'b0});
    chk_port('{xy(f, ve, h), 1'b0});
    chk_port('{8'h80, 1'b0});
  endtask
  task automatic run_lines(input int n, input logic f, input logic fs);
    for (int i = 0; i < n; i++) send(sb(8'h10, 1'b0, 2'h0, 1'b0, 1'b0, f, 1'b1, fs && i == 0), 1'b0);
    idle;
    repeat (3) @(posedge i_clock);
    u_ofac_port_sink.got_q.delete();
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_registers;
    rd(8'h14, r);
    chk8(r, 8'h00);
    chk8(8'(o_reencoder_compat_mode), 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, r);
    chk8(r, 8'h00);
    wr(8'h13, 8'hfa);
    rd(8'h13, r);
    chk8(r, 8'h02);
    for (int k = 0; k < 4; k++) begin
      d = {k[0], k[1], k[1:0], 1'b0, k[0], ~k[1:0]};
      wr(8'h14, d);
      rd(8'h14, r);
      chk8(r, d);
      chk8(8'(o_reencoder_compat_mode), 8'(d[7]));
      chk8(8'(o_gain_update_interval), 8'(d[6]));
      chk8(8'(o_analog_test_select), 8'(d[5:4]));
      chk8(8'(o_legacy_status_layout), 8'(d[2]));
      chk8(8'(o_sample_clock_phase), 8'(d[1:0]));
    end
    i_decoder_status <= 8'h3c;
    wr(8'h1f, 8'hff);
    wr(8'h14, 8'h04);
    rd(8'h1f, r);
    chk8(r, 8'hc3);
    wr(8'h14, 8'h00);
    rd(8'h1f, r);
    chk8(r, 8'h3c);
  endtask
  task automatic t_formats;
    wr(8'h13, 8'h00);
    for (int i = 0; i < 8; i++) send_code(i[2], i[1], i[0], i[1]);
    wr(8'h13, 8'h02);
    for (int i = 0; i < 4; i++) send(sb(8'h11, 1'b1, 2'(i), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 1'b0);
    send(sb(8'h40, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    idle;
    chk_port('{8'h40, 1'b1});
    repeat (6) @(posedge i_clock);
    chk8(8'(u_ofac_port_sink.got_q.size()), 8'h00);
    for (int k = 0; k < 9; k++) begin
      wr(8'h13, {5'h00, BYP[k][13:11]});
      i_conv <= {BYP[k][10:9], 9'h1a5, 9'h0c3};
      send(sb(8'h00, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), BYP[k][8]);
      idle;
      chk_port({BYP[k][7:0], BYP[k][8]});
    end
  endtask
  task automatic t_stall;
    wr(8'h13, 8'h00);
    sink_hold <= 1'b1;
    @(posedge i_clock);
    for (int i = 0; i < 2; i++) send(sb(8'ha0 + 8'(i), 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 1'b0);
    idle;
    chk8(8'(o_stream_ready), 8'h00);
    sink_hold <= 1'b0;
    sink_slow <= 1'b1;
    for (int i = 0; i < 2; i++) chk_port('{8'ha0 + 8'(i), 1'b0});
    sink_slow <= 1'b0;
  endtask
  task automatic t_gate;
    wr(8'h13, 8'h01);
    wr(8'h15, 8'h01);
    wr(8'h16, 8'h04);
    wr(8'h17, 8'h03);
    run_lines(257, 1'b0, 1'b1);
    chk8(8'(o_vertical_gate_window), 8'h00);
    run_lines(1, 1'b0, 1'b0);
    chk8(8'({o_vertical_gate_window, o_field_identifier}), 8'h02);
    send_code(1'b0, 1'b0, 1'b1, 1'b1);
    run_lines(3, 1'b0, 1'b0);
    chk8(8'(o_vertical_gate_window), 8'h00);
    send_code(1'b0, 1'b1, 1'b0, 1'b0);
    wr(8'h17, 8'h07);
    wr(8'h14, 8'h40);
    run_lines(256, 1'b1, 1'b1);
    chk8(8'(o_vertical_gate_window), 8'h00);
    run_lines(1, 1'b1, 1'b0);
    chk8(8'({o_vertical_gate_window, o_field_identifier}), 8'h03);
  endtask
  // --------
  // main sequence and watchdog
  // --------
  initial begin
    i_reset = 1'b1;
    i_reg = '0;
    i_stream_valid = 1'b0;
    i_stream = '0;
    i_conv = '0;
    i_clock_reference_qualifier = 1'b0;
    i_decoder_status = 8'h00;
    sink_hold = 1'b0;
    sink_slow = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    t_registers;
    t_formats;
    t_stall;
    t_gate;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict;
  end
endmodule

bind ofac_output_format ofac_output_format_properties u_ofac_output_format_properties (.*);
